// ### hw/ibpc_core.v
`timescale 1ns/10ps
`include "ibpc_regs.vh"
module ibpc_core #(
  parameter HALF_CYCLES = `IBPC_HALF_CYCLES
) (
  input wire clock,
  input wire resetn,
  input wire serialPortEnable,
  input wire sclIn,
  output reg sclOut,
  output reg sclOe,
  input wire sdaIn,
  output reg sdaOut,
  output reg sdaOe,
  input wire cmdValid,
  output reg cmdReady,
  input wire [6:0] cmdAddr,
  input wire cmdRead,
  input wire [7:0] cmdCount,
  input wire cmdRepeat,
  input wire txValid,
  output wire txReady,
  input wire [7:0] txData,
  output reg rxValid,
  input wire rxReady,
  output reg [7:0] rxData,
  output reg busBusy,
  output reg arbLost,
  output reg nackSeen,
  output reg done
);
  localparam S_IDLE = 4'h0;
  localparam S_START = 4'h1;
  localparam S_LOW = 4'h2;
  localparam S_HIGH = 4'h3;
  localparam S_STOP1 = 4'h4;
  localparam S_STOP2 = 4'h5;
  localparam S_STOP3 = 4'h6;
  localparam S_RS1 = 4'h7;
  localparam S_RS2 = 4'h8;
  localparam S_WAITSTOP = 4'h9;
  localparam S_LOAD = 4'hA;
  localparam S_STALL = 4'hB;

  wire scl;
  wire sda;
  wire sdaChg;
  reg sdaPrev_q;
  reg [3:0] state_q;
  reg [15:0] timer_q;
  reg [3:0] bitCnt_q;
  reg [7:0] shift_q;
  reg [7:0] left_q;
  reg isRead_q;
  reg isAddr_q;
  reg repeat_q;
  reg drvSdaLow_q;
  reg drvSclLow_q;
  reg bitRx_q;
  wire timeUp;
  wire startSeen;
  wire stopSeen;
  wire fifoValid;
  wire [7:0] fifoData;
  reg fifoTake;

  ibpc_sync #(.RESET_VALUE(1'b1)) uSyncScl (
    .clock(clock),
    .resetn(resetn),
    .async(sclIn),
    .level(scl),
    .changed()
  );
  ibpc_sync #(.RESET_VALUE(1'b1)) uSyncSda (
    .clock(clock),
    .resetn(resetn),
    .async(sdaIn),
    .level(sda),
    .changed(sdaChg)
  );
  ibpc_fifo #(.WIDTH(8), .DEPTH(`IBPC_FIFO_DEPTH), .AW(`IBPC_FIFO_AW)) uTxFifo (
    .clock(clock),
    .resetn(resetn),
    .inValid(txValid),
    .inReady(txReady),
    .inData(txData),
    .outValid(fifoValid),
    .outReady(fifoTake),
    .outData(fifoData)
  );

  assign timeUp = (timer_q == 16'h0000);
  assign startSeen = sdaChg && !sda && scl && sdaPrev_q;
  assign stopSeen = sdaChg && sda && scl && !sdaPrev_q;

  // Bus busy tracking from observed conditions
  always @(posedge clock)
  begin
    if (!resetn || !serialPortEnable)
    begin
      sdaPrev_q <= 1'b1;
      busBusy <= 1'b0;
    end
    else
    begin
      sdaPrev_q <= sda;
      if (startSeen)
      begin
        busBusy <= 1'b1;
      end
      else if (stopSeen)
      begin
        busBusy <= 1'b0;
      end
    end
  end

  // Open-drain pins: value zero, enable means pull low
  always @(posedge clock)
  begin
    if (!resetn)
    begin
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
      sclOe <= 1'b0;
      sdaOe <= 1'b0;
    end
    else
    begin
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
      sclOe <= serialPortEnable && drvSclLow_q;
      sdaOe <= serialPortEnable && drvSdaLow_q;
    end
  end

  // Bit level master engine
  always @(posedge clock)
  begin
    fifoTake <= 1'b0;
    if (!resetn || !serialPortEnable)
    begin
      state_q <= S_IDLE;
      timer_q <= 16'h0000;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      left_q <= 8'h00;
      isRead_q <= 1'b0;
      isAddr_q <= 1'b0;
      repeat_q <= 1'b0;
      drvSdaLow_q <= 1'b0;
      drvSclLow_q <= 1'b0;
      bitRx_q <= 1'b0;
      cmdReady <= 1'b0;
      rxValid <= 1'b0;
      rxData <= 8'h00;
      arbLost <= 1'b0;
      nackSeen <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      arbLost <= 1'b0;
      nackSeen <= 1'b0;
      if (rxValid && rxReady)
      begin
        rxValid <= 1'b0;
      end
      if (!timeUp)
      begin
        timer_q <= timer_q - 16'h0001;
      end
      cmdReady <= (((state_q == S_IDLE) && !busBusy)
                   || ((state_q == S_WAITSTOP) && drvSdaLow_q && timeUp)) && !cmdReady;
      case (state_q)
        S_IDLE:
        begin
          drvSdaLow_q <= 1'b0;
          drvSclLow_q <= 1'b0;
          if (cmdValid && cmdReady && !busBusy)
          begin
            shift_q <= {cmdAddr, cmdRead};
            isRead_q <= (cmdRead == `IBPC_DIR_READ);
            left_q <= cmdCount;
            repeat_q <= cmdRepeat;
            isAddr_q <= 1'b1;
            drvSdaLow_q <= 1'b1;
            timer_q <= HALF_CYCLES[15:0];
            cmdReady <= 1'b0;
            state_q <= S_START;
          end
        end
        S_START:
        begin
          if (timeUp)
          begin
            drvSclLow_q <= 1'b1;
            bitCnt_q <= 4'h0;
            timer_q <= HALF_CYCLES[15:0];
            state_q <= S_LOW;
          end
        end
        S_LOW:
        begin
          if (timeUp)
          begin
            drvSclLow_q <= 1'b0;
            state_q <= S_HIGH;
            timer_q <= HALF_CYCLES[15:0];
          end
          else if (timer_q == HALF_CYCLES[16:1])
          begin
            if (bitCnt_q == `IBPC_ACK_BIT)
            begin
              // Receiver acknowledges all but the last read byte, sender releases
              drvSdaLow_q <= (!isAddr_q && isRead_q) ? (left_q != 8'h01) : 1'b0;
            end
            else if (!isAddr_q && isRead_q)
            begin
              drvSdaLow_q <= 1'b0;
            end
            else
            begin
              drvSdaLow_q <= !shift_q[7];
            end
          end
        end
        S_HIGH:
        begin
          if (!scl)
          begin
            timer_q <= HALF_CYCLES[15:0];
          end
          else if (timer_q == HALF_CYCLES[16:1])
          begin
            bitRx_q <= sda;
            if (drvSdaLow_q == 1'b0 && sda == 1'b0 && bitCnt_q != `IBPC_ACK_BIT
                && !(isRead_q && !isAddr_q))
            begin
              drvSdaLow_q <= 1'b0;
              drvSclLow_q <= 1'b0;
              arbLost <= 1'b1;
              state_q <= S_WAITSTOP;
            end
          end
          if (scl && timeUp)
          begin
            drvSclLow_q <= 1'b1;
            timer_q <= HALF_CYCLES[15:0];
            if (bitCnt_q == `IBPC_ACK_BIT)
            begin
              state_q <= S_LOAD;
            end
            else
            begin
              shift_q <= {shift_q[6:0], bitRx_q};
              bitCnt_q <= bitCnt_q + 4'h1;
              state_q <= S_LOW;
            end
          end
        end
        S_LOAD:
        begin
          if (isRead_q && !isAddr_q)
          begin
            rxData <= shift_q;
            rxValid <= 1'b1;
          end
          if (!isRead_q && bitRx_q)
          begin
            nackSeen <= 1'b1;
            state_q <= S_STOP1;
          end
          else if ((!isAddr_q && left_q == 8'h01) || left_q == 8'h00)
          begin
            state_q <= repeat_q ? S_RS1 : S_STOP1;
          end
          else
          begin
            state_q <= S_STALL;
          end
          if (!isAddr_q)
          begin
            left_q <= left_q - 8'h01;
          end
          isAddr_q <= 1'b0;
          bitCnt_q <= 4'h0;
        end
        S_STALL:
        begin
          // Hold SCL low until data or room available
          if (isRead_q ? !rxValid : fifoValid)
          begin
            if (!isRead_q)
            begin
              shift_q <= fifoData;
              fifoTake <= 1'b1;
            end
            timer_q <= HALF_CYCLES[15:0];
            state_q <= S_LOW;
          end
        end
        S_STOP1:
        begin
          if (timer_q == HALF_CYCLES[16:1])
          begin
            drvSdaLow_q <= 1'b1;
          end
          if (timeUp)
          begin
            drvSclLow_q <= 1'b0;
            timer_q <= HALF_CYCLES[15:0];
            state_q <= S_STOP2;
          end
        end
        S_STOP2:
        begin
          if (!scl)
          begin
            timer_q <= HALF_CYCLES[15:0];
          end
          else if (timeUp)
          begin
            drvSdaLow_q <= 1'b0;
            timer_q <= HALF_CYCLES[15:0];
            state_q <= S_STOP3;
          end
        end
        S_STOP3:
        begin
          if (timeUp)
          begin
            done <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        S_RS1:
        begin
          if (timer_q == HALF_CYCLES[16:1])
          begin
            drvSdaLow_q <= 1'b0;
          end
          if (timeUp)
          begin
            drvSclLow_q <= 1'b0;
            timer_q <= HALF_CYCLES[15:0];
            state_q <= S_RS2;
          end
        end
        S_RS2:
        begin
          if (!scl)
          begin
            timer_q <= HALF_CYCLES[15:0];
          end
          else if (timeUp)
          begin
            done <= 1'b1;
            state_q <= S_WAITSTOP;
            drvSdaLow_q <= 1'b1;
            timer_q <= HALF_CYCLES[15:0];
          end
        end
        S_WAITSTOP:
        begin
          // Repeated start holds the bus; arbitration loss waits for stop
          if (drvSdaLow_q)
          begin
            if (cmdValid && cmdReady)
            begin
              cmdReady <= 1'b0;
              shift_q <= {cmdAddr, cmdRead};
              isRead_q <= (cmdRead == `IBPC_DIR_READ);
              left_q <= cmdCount;
              repeat_q <= cmdRepeat;
              isAddr_q <= 1'b1;
              state_q <= S_START;
            end
          end
          else if (stopSeen || !busBusy)
          begin
            state_q <= S_IDLE;
          end
        end
        default:
        begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule // ibpc_core

// ### hw/ibpc_fifo.v
`timescale 1ns/10ps
module ibpc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clock,
  input wire resetn,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output reg outValid,
  input wire outReady,
  output reg [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_q;
  reg [AW-1:0] rdPtr_q;
  reg [AW:0] count_q;
  reg [AW:0] fill_q;
  reg notFull_q;
  wire [AW:0] fillNext;
  wire doWrite;
  wire doRead;
  // Fill counts the output register too, so the depth is exact
  assign inReady = notFull_q;
  assign fillNext = fill_q + {{AW{1'b0}}, doWrite} - {{AW{1'b0}}, (outValid && outReady)};
  assign doWrite = inValid && inReady;
  assign doRead = (count_q != {(AW+1){1'b0}}) && (!outValid || outReady);
  always @(posedge clock)
  begin
    if (doWrite)
    begin
      mem[wrPtr_q] <= inData;
    end
  end
  always @(posedge clock)
  begin
    if (!resetn)
    begin
      wrPtr_q <= {AW{1'b0}};
      rdPtr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
      outValid <= 1'b0;
      outData <= {WIDTH{1'b0}};
      fill_q <= {(AW+1){1'b0}};
      notFull_q <= 1'b1;
    end
    else
    begin
      if (doWrite)
      begin
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (doRead)
      begin
        rdPtr_q <= rdPtr_q + 1'b1;
        outData <= mem[rdPtr_q];
        outValid <= 1'b1;
      end
      else if (outReady)
      begin
        outValid <= 1'b0;
      end
      count_q <= count_q + {{AW{1'b0}}, doWrite} - {{AW{1'b0}}, doRead};
      fill_q <= fillNext;
      notFull_q <= (fillNext != DEPTH[AW:0]);
    end
  end
endmodule // ibpc_fifo

// ### hw/ibpc_sync.v
`timescale 1ns/10ps
module ibpc_sync #(
  parameter RESET_VALUE = 1'b1
) (
  input wire clock,
  input wire resetn,
  input wire async,
  output reg level,
  output reg changed
);
  reg stage1_q;
  reg stage2_q;
  reg stage3_q;
  // Change counts once stages two and three agree
  always @(posedge clock)
  begin
    if (!resetn)
    begin
      stage1_q <= RESET_VALUE;
      stage2_q <= RESET_VALUE;
      stage3_q <= RESET_VALUE;
      level <= RESET_VALUE;
      changed <= 1'b0;
    end
    else
    begin
      stage1_q <= async;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      changed <= (stage2_q == stage3_q) && (stage3_q != level);
      if (stage2_q == stage3_q)
      begin
        level <= stage3_q;
      end
    end
  end
endmodule // ibpc_sync

// ### pkg/ibpc_regs.vh
`ifndef IBPC_REGS_VH
`define IBPC_REGS_VH
`define IBPC_CLK_MHZ 250
`define IBPC_BUS_PERIOD_NS 10000
`define IBPC_HALF_CYCLES ((`IBPC_BUS_PERIOD_NS * `IBPC_CLK_MHZ) / 2000)
`define IBPC_BITS_PER_SEGMENT 9
`define IBPC_ACK_BIT 4'h8
`define IBPC_DIR_READ 1'b1
`define IBPC_DIR_WRITE 1'b0
`define IBPC_FIFO_DEPTH 16
`define IBPC_FIFO_AW 4
`endif

// ### tb/ibpc_core_properties.sv
`timescale 1ns/10ps
module ibpc_core_checker #(
  parameter HALF_CYCLES = 8
) (
  input wire clock,
  input wire resetn,
  input wire serialPortEnable,
  input wire sclIn,
  input wire sclOut,
  input wire sclOe,
  input wire sdaOut,
  input wire sdaOe,
  input wire cmdValid,
  input wire cmdReady,
  input wire busBusy,
  input wire arbLost,
  input wire nackSeen,
  input wire done
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  a_pins_pull_only:
    assert property (!sclOut && !sdaOut) else $error("pin data not zero");
  a_off_release:
    assert property (!serialPortEnable |=> !sclOe && !sdaOe) else $error("pins held when off");
  a_cmd_start:
    assert property (serialPortEnable && cmdValid && cmdReady && !busBusy && !sdaOe
      |-> ##2 sdaOe && !sclOe) else $error("no start after command");
  a_idle_start:
    assert property ($rose(sdaOe) && !busBusy |-> !sclOe && sclIn) else $error("bad start");
  a_arb_release:
    assert property (arbLost |-> ##1 (!sdaOe && !sclOe) [*4]) else $error("held after loss");
  a_stretch_wait:
    assert property ($fell(sclOe) ##1 !sclIn [*8] |-> !sclOe) else $error("pulled in stretch");
  a_nack_stop:
    assert property (nackSeen |-> ##[0:60] ($fell(sdaOe) && !sclOe)) else $error("no stop");
  a_done_idle:
    assert property (done |-> !sdaOe && !sclOe) else $error("lines held at done");
endmodule // ibpc_core_checker
bind ibpc_core ibpc_core_checker #(.HALF_CYCLES(HALF_CYCLES)) chk (
  .clock(clock), .resetn(resetn), .serialPortEnable(serialPortEnable), .sclIn(sclIn),
  .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe), .cmdValid(cmdValid),
  .cmdReady(cmdReady), .busBusy(busBusy), .arbLost(arbLost), .nackSeen(nackSeen), .done(done)
);

// ### tb/ibpc_core_tb.sv
`timescale 1ns/10ps
module ibpc_core_tb;
  localparam [6:0] SLV = 7'h5A;
  reg clock, resetn, serialPortEnable, cmdValid, cmdRead, cmdRepeat;
  reg txValid, rxReady, stretch, tbSda, sawNack, sawArb;
  reg [6:0] cmdAddr;
  reg [7:0] cmdCount, txData;
  reg [7:0] rxLog [0:7];
  wire sclOe, sdaOe, cmdReady, txReady, rxValid, busBusy, arbLost, nackSeen, done;
  wire slvScl, slvSda;
  wire [7:0] rxData;
  wire sclLine = ~(sclOe | slvScl);
  wire sdaLine = ~(sdaOe | slvSda | tbSda);
  integer n_errors, cmp_count, rxCnt, k, s0, p0;
  ibpc_core #(.HALF_CYCLES(6)) uut (
    .clock(clock), .resetn(resetn), .serialPortEnable(serialPortEnable), .sclIn(sclLine),
    .sclOut(), .sclOe(sclOe), .sdaIn(sdaLine), .sdaOut(), .sdaOe(sdaOe), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdAddr(cmdAddr), .cmdRead(cmdRead), .cmdCount(cmdCount),
    .cmdRepeat(cmdRepeat), .txValid(txValid), .txReady(txReady), .txData(txData),
    .rxValid(rxValid), .rxReady(rxReady), .rxData(rxData), .busBusy(busBusy),
    .arbLost(arbLost), .nackSeen(nackSeen), .done(done)
  );
  ibpc_slave_model #(.ADDR(SLV)) slv (
    .scl(sclLine), .sda(sdaLine), .stretch(stretch), .sclPull(slvScl), .sdaPull(slvSda)
  );
  initial
  begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end
  task conclude;
    begin
      if (n_errors == 0 && cmp_count > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input bad, input [8*20:1] msg);
    begin
      cmp_count = cmp_count + 1;
      if (bad)
      begin
        n_errors = n_errors + 1;
        $display("wrong value at %0t: %0s", $time, msg);
      end
    end
  endtask
  task step;
    begin
      @(posedge clock);
      #1;
    end
  endtask
  task issue(input [6:0] a, input r, input [7:0] n, input rep, input busyOk);
    begin
      cmdAddr = a;
      cmdRead = r;
      cmdCount = n;
      cmdRepeat = rep;
      cmdValid = 1'h1;
      for (k = 0; k < 400 && !(cmdReady === 1'h1 && (busyOk || busBusy === 1'h0)); k = k + 1)
        step;
      chk(k == 400, "command not taken");
      if (k == 400)
        conclude;
      step;
      cmdValid = 1'h0;
    end
  endtask
  task waitDone(input integer lim, input must);
    begin
      for (k = 0; k < lim && done !== 1'h1; k = k + 1)
      begin
        sawNack = sawNack | (nackSeen === 1'h1);
        sawArb = sawArb | (arbLost === 1'h1);
        rxReady = k > 150;
        if (rxValid === 1'h1 && rxReady && rxCnt < 8)
        begin
          rxLog[rxCnt] = rxData;
          rxCnt = rxCnt + 1;
        end
        step;
      end
      chk(must && k == lim, "no completion");
      if (must && k == lim)
        conclude;
    end
  endtask
  initial
  begin
    {resetn, cmdValid, cmdRead, cmdRepeat, txValid, rxReady, stretch, tbSda} = 8'h00;
    {cmdAddr, cmdCount, txData} = 23'h0;
    {sawNack, sawArb} = 2'h0;
    serialPortEnable = 1'h1;
    n_errors = 0;
    cmp_count = 0;
    rxCnt = 0;
    repeat (3) @(posedge clock);
    #1;
    resetn = 1'h1;
    repeat (4) step;
    // Fill until refused, then drain with the slave stretching
    txValid = 1'h1;
    for (k = 0; k < 20 && txReady === 1'h1; k = k + 1)
    begin
      txData = 8'h3C ^ k[7:0];
      step;
    end
    txValid = 1'h0;
    chk(k !== 16, "fifo depth");
    stretch = 1'h1;
    issue(SLV, 1'h0, 8'h10, 1'h0, 1'h0);
    waitDone(6000, 1'h1);
    stretch = 1'h0;
    chk(slv.adr !== {SLV, 1'h0}, "write address");
    for (k = 0; k < 16; k = k + 1)
      chk(slv.wrLog[k] !== (8'h3C ^ k[7:0]), "write data");
    chk(sawNack !== 1'h0, "write refused");
    // Read with the receive side stalled
    issue(SLV, 1'h1, 8'h02, 1'h0, 1'h0);
    waitDone(3000, 1'h1);
    chk(slv.adr !== {SLV, 1'h1}, "read address");
    chk(rxCnt !== 2 || rxLog[0] !== 8'hA5, "read byte 0");
    chk(rxLog[1] !== 8'hA4, "read byte 1");
    chk(slv.ackIn !== 1'h1, "last ack");
    // Repeated start between two reads
    s0 = slv.nStart;
    p0 = slv.nStop;
    issue(SLV, 1'h1, 8'h01, 1'h1, 1'h0);
    waitDone(1000, 1'h1);
    chk(busBusy !== 1'h1, "bus dropped");
    issue(SLV, 1'h1, 8'h01, 1'h0, 1'h1);
    waitDone(2000, 1'h1);
    chk(slv.nStart - s0 !== 2 || slv.nStop - p0 !== 1, "repeated start");
    // Foreign start holds off a command
    tbSda = 1'h1;
    repeat (10) step;
    chk(busBusy !== 1'h1, "foreign start");
    cmdValid = 1'h1;
    for (s0 = 0; s0 < 60; s0 = s0 + 1)
    begin
      step;
      chk((sclOe | sdaOe) !== 1'h0, "start while busy");
    end
    tbSda = 1'h0;
    issue(SLV, 1'h1, 8'h01, 1'h0, 1'h0);
    waitDone(2000, 1'h1);
    // Unknown address is refused
    txData = 8'h96;
    txValid = 1'h1;
    step;
    txValid = 1'h0;
    issue(7'h21, 1'h0, 8'h01, 1'h0, 1'h0);
    waitDone(2000, 1'h1);
    chk(sawNack !== 1'h1, "refusal unseen");
    // Another master wins the first address bit
    issue(7'h7F, 1'h0, 8'h01, 1'h0, 1'h0);
    for (k = 0; k < 200 && sclOe !== 1'h1; k = k + 1)
      step;
    chk(k == 200, "no start");
    tbSda = 1'h1;
    waitDone(300, 1'h0);
    chk(sawArb !== 1'h1, "no arbitration loss");
    chk((sclOe | sdaOe) !== 1'h0, "lines kept");
    tbSda = 1'h0;
    repeat (20) step;
    chk(busBusy !== 1'h0, "bus not idle");
    // Port switched off mid transfer
    issue(SLV, 1'h1, 8'h01, 1'h0, 1'h0);
    repeat (40) step;
    serialPortEnable = 1'h0;
    repeat (2) step;
    chk((sclOe | sdaOe | busBusy) !== 1'h0, "port off");
    conclude;
  end
endmodule // ibpc_core_tb

// ### tb/ibpc_slave_model.sv
`timescale 1ns/10ps
module ibpc_slave_model #(
  parameter [6:0] ADDR = 7'h5A
) (
  input wire scl,
  input wire sda,
  input wire stretch,
  output reg sclPull,
  output reg sdaPull
);
  reg [7:0] sh, adr, rdB;
  reg [7:0] wrLog [0:31];
  reg act, rd, aPh, skip, ackIn;
  integer n, wrCnt, rdCnt, nStart, nStop;
  initial
  begin
    sclPull = 1'h0;
    sdaPull = 1'h0;
    act = 1'h0;
    wrCnt = 0;
    rdCnt = 0;
    nStart = 0;
    nStop = 0;
  end
  always @(negedge sda)
    if (scl === 1'h1)
    begin
      nStart = nStart + 1;
      act = 1'h1;
      aPh = 1'h1;
      skip = 1'h1;
      n = 0;
    end
  always @(posedge sda)
    if (scl === 1'h1)
    begin
      nStop = nStop + 1;
      act = 1'h0;
    end
  always @(posedge scl)
    if (act && n < 8)
      sh = {sh[6:0], sda};
    else if (act)
      ackIn = sda;
  always @(negedge scl)
    if (act)
    begin
      if (skip)
        skip = 1'h0;
      else
        n = n + 1;
      if (n == 8 && aPh)
      begin
        adr = sh;
        rd = sh[0];
        act = sh[7:1] == ADDR;
        sdaPull = act;
      end
      else if (n == 8 && !rd)
      begin
        wrLog[wrCnt] = sh;
        wrCnt = wrCnt + 1;
        sdaPull = 1'h1;
      end
      else if (n == 8)
        sdaPull = 1'h0;
      else if (n == 9)
      begin
        n = 0;
        sdaPull = 1'h0;
        if (rd && (aPh || !ackIn))
        begin
          rdB = 8'hA5 ^ rdCnt[7:0];
          rdCnt = rdCnt + 1;
          sdaPull = !rdB[7];
        end
        aPh = 1'h0;
        if (stretch)
        begin
          sclPull = 1'h1;
          #200 sclPull = 1'h0;
        end
      end
      else if (rd && !aPh && n > 0)
        sdaPull = !rdB[7 - n];
    end
endmodule // ibpc_slave_model
